// file: dv/dsc_chip_model.sv
// Behavioural model of one converter chip on its serial, reset, load and fault pins
`default_nettype none

module dsc_chip_model (
    input wire logic sclk,
    input wire logic sdin,
    input wire logic sync_n,
    input wire logic reset_n,
    input wire logic ldac_n,
    input wire logic fault_on,
    output logic fault_n,
    output logic [31:0] frame,
    output int n_frames,
    output int n_resets,
    output int n_convs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] shift = 32'h0000_0000;

    initial begin
        frame = 32'h0000_0000;
        n_frames = 0;
        n_resets = 0;
        n_convs = 0;
    end

    // Fault pin is driven low while the bench commands a fault
    assign fault_n = ~fault_on;

    // Capture data on rising serial clock within the frame, MSB first
    always @(posedge sclk) begin
        if (!sync_n) begin
            shift = {shift[30:0], sdin};
        end
    end

    // Frame ends when the select goes high again
    always @(posedge sync_n) begin
        frame = shift;
        n_frames++;
    end

    // Count reset pulses and conversion pulses
    always @(negedge reset_n) n_resets++;
    always @(negedge ldac_n) n_convs++;
endmodule : dsc_chip_model

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench of the converter status and configuration block
`include "dsc_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [3:0] reg_be = 4'h0;
    dsc_word_t reg_wdata = 32'h0000_0000;
    dsc_word_t reg_rdata;
    logic reg_rvalid;
    logic [1:0] conv_req = 2'b00;
    logic [1:0] rst_req = 2'b00;
    logic [1:0] fault_n_pin;
    logic [1:0] fault_on = 2'b00;
    logic [1:0] ser_sclk, ser_sdin, ser_sync_n, chip_reset_n, chip_ldac_n;
    logic [31:0] frame [2];
    int n_frames [2];
    int n_resets [2];
    int n_convs [2];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int seed = 32'h65471240;
    logic [11:0] ofs [2] = '{`DSC_OFS_CFG1, `DSC_OFS_CFG2};
    logic [3:0] bes [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
    dsc_range_t codes [6] = '{DSC_RANGE_0_5V, DSC_RANGE_0_10V, DSC_RANGE_PM5V,
        DSC_RANGE_PM10V, DSC_RANGE_4_20MA, DSC_RANGE_0_24MA};
    dsc_word_t exp_cfg [2] = '{32'h0000_0000, 32'h0000_0000};
    dsc_word_t d, w;
    int nc, nr;

    always #5 clk = ~clk;

    dsc_top i_dsc_top (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_req(conv_req), .rst_req(rst_req),
        .fault_n_pin(fault_n_pin), .ser_sclk(ser_sclk), .ser_sdin(ser_sdin),
        .ser_sync_n(ser_sync_n), .chip_reset_n(chip_reset_n), .chip_ldac_n(chip_ldac_n));

    // One chip model per converter
    for (genvar g = 0; g < 2; g++) begin : g_chip
        dsc_chip_model i_dsc_chip_model (.sclk(ser_sclk[g]), .sdin(ser_sdin[g]),
            .sync_n(ser_sync_n[g]), .reset_n(chip_reset_n[g]), .ldac_n(chip_ldac_n[g]),
            .fault_on(fault_on[g]), .fault_n(fault_n_pin[g]), .frame(frame[g]),
            .n_frames(n_frames[g]), .n_resets(n_resets[g]), .n_convs(n_convs[g]));
    end

    // Stored word after a byte-lane write, reserved bits read zero
    function automatic dsc_word_t merge(dsc_word_t o, dsc_word_t v, logic [3:0] be);
        dsc_word_t r;
        r = o;
        for (int k = 0; k < 4; k++) if (be[k]) r[8*k+:8] = v[8*k+:8];
        return r & `DSC_CFG_MASK;
    endfunction : merge

    task automatic wr(logic [11:0] a, dsc_word_t v, logic [3:0] be);
        @(posedge clk) #1 {reg_wr, reg_addr, reg_wdata, reg_be} = {1'b1, a, v, be};
        @(posedge clk) #1 reg_wr = 1'b0;
    endtask : wr

    // Read answer stands just after the taking edge, which registers it
    task automatic rd(logic [11:0] a, output dsc_word_t v);
        @(posedge clk) #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #1 reg_rd = 1'b0;
        v = reg_rvalid ? reg_rdata : 32'hxxxx_xxxx;
    endtask : rd

    // Poll busy until clear, as software must before the next operation
    task automatic wait_idle();
        dsc_word_t s;
        for (int k = 0; k < 500; k++) begin
            rd(`DSC_OFS_STATUS, s);
            if (s[1:0] === 2'b00) return;
        end
        errors++;
        $display("wrong value busy exp 0 got %b", s[1:0]);
    endtask : wait_idle

    task automatic close_out();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        rd(`DSC_OFS_STATUS, d);
        `CHK("status", 32'h0000_0300, d)
        rd(`DSC_OFS_CFG1, d);
        `CHK("cfg1", 32'h0000_0000, d)
        rd(`DSC_OFS_CFG2, d);
        `CHK("cfg2", 32'h0000_0000, d)
        rd(12'h160, d);
        `CHK("unmapped", 32'h0000_0000, d)
        wr(`DSC_OFS_STATUS, 32'hffff_ffff, 4'hf);
        rd(`DSC_OFS_STATUS, d);
        `CHK("status", 32'h0000_0300, d)
        // Full-word configuration of both converters
        for (int i = 0; i < 2; i++) begin
            w = $random(seed);
            wr(ofs[i], w, 4'hf);
            exp_cfg[i] = merge(exp_cfg[i], w, 4'hf);
            rd(`DSC_OFS_STATUS, d);
            `CHK("busy", 1'b1, d[i])
            wait_idle();
            `CHK("frame", exp_cfg[i], frame[i])
            rd(ofs[i], d);
            `CHK("cfg", exp_cfg[i], d)
        end
        // Byte and half-word lanes
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            nc = n_frames[1];
            wr(`DSC_OFS_CFG2, w, bes[i]);
            exp_cfg[1] = merge(exp_cfg[1], w, bes[i]);
            wait_idle();
            `CHK("frame", exp_cfg[1], frame[1])
            `CHK("frames", nc + 1, n_frames[1])
            rd(`DSC_OFS_CFG2, d);
            `CHK("cfg2", exp_cfg[1], d)
        end
        // Every range code with over-range, power-up and enable in channel D
        for (int i = 0; i < 6; i++) begin
            w = {4'h7, codes[i], 24'h00_0000};
            wr(`DSC_OFS_CFG1, w, 4'h8);
            exp_cfg[0] = merge(exp_cfg[0], w, 4'h8);
            wait_idle();
            rd(`DSC_OFS_CFG1, d);
            `CHK("range", exp_cfg[0], d)
        end
        // Conversion, busy, then fixed settle interval
        nc = n_convs[0];
        @(posedge clk) #1 conv_req = 2'b11;
        @(posedge clk) #1 conv_req = 2'b00;
        wait_idle();
        `CHK("convs", nc + 1, n_convs[0])
        rd(`DSC_OFS_STATUS, d);
        `CHK("settled", 2'b00, d[9:8])
        repeat (2200) @(posedge clk);
        rd(`DSC_OFS_STATUS, d);
        `CHK("settled", 2'b00, d[9:8])
        repeat (200) @(posedge clk);
        rd(`DSC_OFS_STATUS, d);
        `CHK("settled", 2'b11, d[9:8])
        // Reset request with automatic reconfiguration
        nr = n_resets[1];
        @(posedge clk) #1 rst_req = 2'b11;
        @(posedge clk) #1 rst_req = 2'b00;
        rd(`DSC_OFS_STATUS, d);
        `CHK("busy", 1'b1, d[1])
        wait_idle();
        `CHK("resets", nr + 1, n_resets[1])
        `CHK("frame", exp_cfg[1], frame[1])
        `CHK("frame", exp_cfg[0], frame[0])
        // Fault pins
        @(posedge clk) #1 fault_on = 2'b10;
        repeat (5) @(posedge clk);
        rd(`DSC_OFS_STATUS, d);
        `CHK("fault", 2'b10, d[17:16])
        @(posedge clk) #1 fault_on = 2'b01;
        repeat (5) @(posedge clk);
        rd(`DSC_OFS_STATUS, d);
        `CHK("fault", 2'b01, d[17:16])
        close_out();
    end
endmodule : tb

`default_nettype wire

// file: src/dsc_conv.sv
// Per-converter engine: reset pulse, serial configuration frame and conversion pulse
`include "dsc_defines.svh"
`default_nettype none

module dsc_conv (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_rst,
    input wire logic req_cfg,
    input wire logic req_conv,
    input wire dsc_pkg::dsc_word_t cfg_word,
    output logic take_rst,
    output logic take_cfg,
    output logic take_conv,
    output logic engine_busy,
    output logic ser_sclk,
    output logic ser_sdin,
    output logic ser_sync_n,
    output logic chip_reset_n,
    output logic chip_ldac_n
);
    import dsc_pkg::*;

    dsc_state_t state;
    dsc_count_t cnt;
    dsc_word_t shreg;
    logic [4:0] bitcnt;
    logic [1:0] div;

    // Requests are taken only when idle; reset outranks configuration outranks conversion
    assign take_rst = (state == DSC_IDLE) && req_rst;
    assign take_cfg = (state == DSC_IDLE) && !req_rst && req_cfg;
    assign take_conv = (state == DSC_IDLE) && !req_rst && !req_cfg && req_conv;
    assign engine_busy = (state != DSC_IDLE);

    // Sequencer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= DSC_IDLE;
            cnt <= 16'h0000;
            shreg <= 32'h0000_0000;
            bitcnt <= 5'h00;
            div <= 2'h0;
            ser_sclk <= 1'b0;
            ser_sdin <= 1'b0;
            ser_sync_n <= 1'b1;
            chip_reset_n <= 1'b1;
            chip_ldac_n <= 1'b1;
        end else begin
            case (state)
                DSC_IDLE: begin
                    if (take_rst) begin
                        chip_reset_n <= 1'b0;
                        cnt <= 16'(`DSC_RST_CYC - 1);
                        state <= DSC_RST_PULSE;
                    end else if (take_cfg) begin
                        shreg <= cfg_word;
                        ser_sdin <= cfg_word[31];
                        ser_sync_n <= 1'b0;
                        bitcnt <= 5'(`DSC_FRAME_BITS - 1);
                        div <= 2'h0;
                        state <= DSC_SHIFT;
                    end else if (take_conv) begin
                        chip_ldac_n <= 1'b0;
                        cnt <= 16'(`DSC_CONV_CYC - 1);
                        state <= DSC_CONV_PULSE;
                    end
                end
                DSC_RST_PULSE: begin
                    if (cnt == 16'h0000) begin
                        // Release the chip and reconfigure it at once
                        chip_reset_n <= 1'b1;
                        shreg <= cfg_word;
                        ser_sdin <= cfg_word[31];
                        ser_sync_n <= 1'b0;
                        bitcnt <= 5'(`DSC_FRAME_BITS - 1);
                        div <= 2'h0;
                        state <= DSC_SHIFT;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                DSC_SHIFT: begin
                    if (div == 2'(`DSC_SCLK_HALF_CYC - 1)) begin
                        div <= 2'h0;
                        ser_sclk <= !ser_sclk;
                        if (ser_sclk) begin
                            if (bitcnt == 5'h00) begin
                                ser_sync_n <= 1'b1;
                                cnt <= 16'(`DSC_RECOVERY_CYC - 1);
                                state <= DSC_RECOVER;
                            end else begin
                                shreg <= {shreg[30:0], 1'b0};
                                ser_sdin <= shreg[30];
                                bitcnt <= bitcnt - 5'h01;
                            end
                        end
                    end else begin
                        div <= div + 2'h1;
                    end
                end
                DSC_CONV_PULSE: begin
                    if (cnt == 16'h0000) begin
                        chip_ldac_n <= 1'b1;
                        cnt <= 16'(`DSC_RECOVERY_CYC - 1);
                        state <= DSC_RECOVER;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                DSC_RECOVER: begin
                    if (cnt == 16'h0000) begin
                        state <= DSC_IDLE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= DSC_IDLE;
                end
            endcase
        end
    end
endmodule : dsc_conv

`default_nettype wire

// file: src/dsc_defines.svh
// Offsets, field positions, reset values and timing counts of the converter status block
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// Register byte offsets
`define DSC_OFS_STATUS 12'h15c
`define DSC_OFS_CFG1 12'h168
`define DSC_OFS_CFG2 12'h198

// Status register field positions
`define DSC_ST_BUSY_LSB 0
`define DSC_ST_SETL_LSB 8
`define DSC_ST_FAULT_LSB 16

// Configuration register field positions, channel D down to A
`define DSC_D_OE 30
`define DSC_D_PU 29
`define DSC_D_OV 28
`define DSC_D_OR_LSB 24
`define DSC_C_OE 22
`define DSC_C_PU 21
`define DSC_C_OV 20
`define DSC_C_OR_LSB 16
`define DSC_B_OE 14
`define DSC_B_PU 13
`define DSC_B_OV 12
`define DSC_B_OR_LSB 8
`define DSC_A_OE 6
`define DSC_A_PU 5
`define DSC_A_OV 4
`define DSC_A_OR_LSB 0

// Writable bits of a configuration register; bits 31, 23, 15 and 7 stay zero
`define DSC_CFG_MASK 32'h7f7f_7f7f
`define DSC_CFG_RESET 32'h0000_0000
`define DSC_SETTLED_RESET 1'b1

// Timing, times in ns at a 10 ns clock
`define DSC_CLK_PERIOD_NS 10
`define DSC_SETTLE_NS 24000
`define DSC_CONV_PULSE_NS 100
`define DSC_RECOVERY_NS 500
`define DSC_RST_PULSE_NS 1000
`define DSC_SETTLE_CYC (`DSC_SETTLE_NS / `DSC_CLK_PERIOD_NS)
`define DSC_CONV_CYC ((`DSC_CONV_PULSE_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`define DSC_RECOVERY_CYC ((`DSC_RECOVERY_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`define DSC_RST_CYC ((`DSC_RST_PULSE_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`define DSC_SCLK_HALF_CYC 2
`define DSC_FRAME_BITS 32

`endif

// file: src/dsc_pkg.sv
// Types shared by the converter status and configuration block
`default_nettype none

package dsc_pkg;
    typedef logic [31:0] dsc_word_t;
    typedef logic [15:0] dsc_count_t;

    // Output range codes
    typedef enum logic [3:0] {
        DSC_RANGE_0_5V = 4'h0,
        DSC_RANGE_0_10V = 4'h1,
        DSC_RANGE_PM5V = 4'h3,
        DSC_RANGE_PM10V = 4'h4,
        DSC_RANGE_4_20MA = 4'hc,
        DSC_RANGE_0_24MA = 4'he
    } dsc_range_t;

    // Per-converter engine states
    typedef enum logic [2:0] {
        DSC_IDLE,
        DSC_RST_PULSE,
        DSC_SHIFT,
        DSC_CONV_PULSE,
        DSC_RECOVER
    } dsc_state_t;
endpackage : dsc_pkg

`default_nettype wire

// file: src/dsc_top.sv
// Status and configuration logic for two quad-channel output converters
//
// Functional notes
// - Read-only global status register at 0x15C
// - Fault flags bits 16/17 follow low fault pins
// - Settle flags bits 8/9 mark fixed 24us
// - Busy bits 0/1 cover transfers and recovery
// - Busy also covers reset and auto-reconfiguration
// - Configuration registers at 0x168 and 0x198
// - Configuration writes accept 32, 16, 8 bits
// - Configuration write queues serial transfer to chip
// - Configuration write sets busy until sent
// - Over-range bit widens voltage ranges 20 percent
// - Channel D fields at bits 30..24
// - Channel C fields at bits 22..16
// - Channel B fields at bits 14..12
// - Channel A bits 6..0, B range 11:8
// - Output range codes as listed, others reserved
`include "dsc_defines.svh"
`default_nettype none

module dsc_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire dsc_pkg::dsc_word_t reg_wdata,
    output var dsc_pkg::dsc_word_t reg_rdata,
    output logic reg_rvalid,
    input wire logic [1:0] conv_req,
    input wire logic [1:0] rst_req,
    input wire logic [1:0] fault_n_pin,
    output logic [1:0] ser_sclk,
    output logic [1:0] ser_sdin,
    output logic [1:0] ser_sync_n,
    output logic [1:0] chip_reset_n,
    output logic [1:0] chip_ldac_n
);
    import dsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge of a write into a configuration word, reserved bits forced low
    function automatic dsc_word_t dsc_merge(input dsc_word_t old, input dsc_word_t wd,
                                            input logic [3:0] be);
        dsc_word_t res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & `DSC_CFG_MASK;
    endfunction : dsc_merge

    // Address of the configuration register of one converter
    function automatic logic [11:0] dsc_cfg_addr(input int idx);
        return (idx == 0) ? `DSC_OFS_CFG1 : `DSC_OFS_CFG2;
    endfunction : dsc_cfg_addr

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    dsc_word_t cfg [2];
    logic [1:0] cfg_pending;
    logic [1:0] conv_pending;
    logic [1:0] rst_pending;
    logic [1:0] busy;
    logic [1:0] settled;
    logic [1:0] fault;
    logic [1:0] fault_meta;
    logic [1:0] fault_sync;
    dsc_count_t settle_cnt [2];
    logic [1:0] cfg_wr_hit;
    logic [1:0] take_rst;
    logic [1:0] take_cfg;
    logic [1:0] take_conv;
    logic [1:0] engine_busy;

    // Write strobes per configuration register, any byte lane counts
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cfg_wr_hit[i] = reg_wr && (reg_addr == dsc_cfg_addr(i)) && (reg_be != 4'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Byte-lane writes; fields OE/PU/OV/range per channel pass unchanged to the chip
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg[0] <= `DSC_CFG_RESET;
            cfg[1] <= `DSC_CFG_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cfg_wr_hit[i]) begin
                    cfg[i] <= dsc_merge(cfg[i], reg_wdata, reg_be);
                end
            end
        end
    end
    // Field layout D, C, B, A at 30..24, 22..16, 14..8, 6..0 held by the mask
    // Channel C and B enable/power-up bits sit at 22/21 and 14/13
    // Channel A at 6..0 and B range at 11:8
    // Range codes are stored as written, reserved codes included

    ////////////////////////////////////////////////////////////////////////////////
    // Request queues

    // Pending flags; a new request in the cycle it is taken stays pending
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_pending <= 2'b00;
            conv_pending <= 2'b00;
            rst_pending <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cfg_wr_hit[i]) begin
                    cfg_pending[i] <= 1'b1;
                end else if (take_cfg[i]) begin
                    cfg_pending[i] <= 1'b0;
                end
                if (conv_req[i]) begin
                    conv_pending[i] <= 1'b1;
                end else if (take_conv[i]) begin
                    conv_pending[i] <= 1'b0;
                end
                if (rst_req[i]) begin
                    rst_pending[i] <= 1'b1;
                end else if (take_rst[i]) begin
                    rst_pending[i] <= 1'b0;
                end
            end
        end
    end

    // One engine per converter
    for (genvar g = 0; g < 2; g++) begin : g_conv
        dsc_conv u_conv (
            .clk(clk),
            .resetn(resetn),
            .req_rst(rst_pending[g]),
            .req_cfg(cfg_pending[g]),
            .req_conv(conv_pending[g]),
            .cfg_word(cfg[g]),
            .take_rst(take_rst[g]),
            .take_cfg(take_cfg[g]),
            .take_conv(take_conv[g]),
            .engine_busy(engine_busy[g]),
            .ser_sclk(ser_sclk[g]),
            .ser_sdin(ser_sdin[g]),
            .ser_sync_n(ser_sync_n[g]),
            .chip_reset_n(chip_reset_n[g]),
            .chip_ldac_n(chip_ldac_n[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags

    // Busy covers queued and running work, recovery included, settling excluded
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                busy[i] <= cfg_wr_hit[i] | cfg_pending[i] | conv_pending[i]
                    | rst_pending[i] | rst_req[i] | conv_req[i] | engine_busy[i];
            end
        end
    end

    // Fault pins are asynchronous: two flops before use
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fault_meta <= 2'b11;
            fault_sync <= 2'b11;
        end else begin
            fault_meta <= fault_n_pin;
            fault_sync <= fault_meta;
        end
    end

    // Fault flag set while the pin is low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fault <= 2'b00;
        end else begin
            fault <= ~fault_sync;
        end
    end

    // Settle timers restart at each conversion pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            settled <= {2{`DSC_SETTLED_RESET}};
            settle_cnt[0] <= 16'h0000;
            settle_cnt[1] <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (take_conv[i]) begin
                    settled[i] <= 1'b0;
                    settle_cnt[i] <= 16'(`DSC_SETTLE_CYC);
                end else if (settle_cnt[i] == 16'h0001) begin
                    settled[i] <= 1'b1;
                    settle_cnt[i] <= 16'h0000;
                end else if (settle_cnt[i] != 16'h0000) begin
                    settle_cnt[i] <= settle_cnt[i] - 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    // Registered read data, unmapped offsets read zero, status writes ignored
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= 32'h0000_0000;
            end else if (reg_addr == `DSC_OFS_STATUS) begin
                reg_rdata <= 32'h0000_0000;
                reg_rdata[`DSC_ST_FAULT_LSB +: 2] <= fault;
                reg_rdata[`DSC_ST_SETL_LSB +: 2] <= settled;
                reg_rdata[`DSC_ST_BUSY_LSB +: 2] <= busy;
            end else if (reg_addr == `DSC_OFS_CFG1) begin
                reg_rdata <= cfg[0];
            end else if (reg_addr == `DSC_OFS_CFG2) begin
                reg_rdata <= cfg[1];
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_FAULT_FOLLOWS_PIN: assert property (@(posedge clk) disable iff (!resetn)
        $fell(fault_n_pin[0]) |-> ##3 fault[0])
        else $error("fault flag did not follow low pin");

    AST_SETTLE_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
        take_conv[0] |=> !settled[0])
        else $error("settle flag not cleared at conversion");

    AST_SETTLE_SETS: assert property (@(posedge clk) disable iff (!resetn)
        $rose(settled[0]) |-> $past(settle_cnt[0]) == 16'h0001)
        else $error("settle flag set at wrong time");

    AST_SETTLE_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
        take_conv[1] ##1 !take_conv[1] [*8] |-> !settled[1])
        else $error("settle flag set too early");

    AST_BUSY_ON_CFG_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr_hit[0] |=> busy[0] ##1 busy[0])
        else $error("busy not set after configuration write");

    AST_BUSY_UNTIL_SENT: assert property (@(posedge clk) disable iff (!resetn)
        $rose(ser_sync_n[1]) |=> busy[1])
        else $error("busy dropped before recovery");

    AST_BUSY_IN_RESET: assert property (@(posedge clk) disable iff (!resetn)
        !chip_reset_n[0] |=> busy[0])
        else $error("busy clear during converter reset");

    AST_RESET_RECONFIG: assert property (@(posedge clk) disable iff (!resetn)
        $rose(chip_reset_n[0]) |-> !ser_sync_n[0])
        else $error("no reconfiguration after reset");

    AST_CFG_SENT: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr_hit[1] && !engine_busy[1] && !rst_pending[1] |=> ##[1:2] !ser_sync_n[1])
        else $error("configuration frame not started");

    AST_BYTE_LANES: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr_hit[1] && reg_be == 4'h1 |=> cfg[1][31:8] == $past(cfg[1][31:8]))
        else $error("byte write touched other lanes");

    AST_FULL_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        cfg_wr_hit[1] && reg_be == 4'hf |=> cfg[1] == ($past(reg_wdata) & `DSC_CFG_MASK))
        else $error("configuration word not stored");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        {cfg[0][31], cfg[0][23], cfg[0][15], cfg[0][7]} == 4'h0)
        else $error("reserved configuration bit set");

    AST_STATUS_LAYOUT: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == `DSC_OFS_STATUS |=> reg_rdata[31:18] == 14'h0000
        && reg_rdata[15:10] == 6'h00 && reg_rdata[7:2] == 6'h00 && reg_rvalid)
        else $error("status reserved bits not zero");
endmodule : dsc_top

`default_nettype wire
